// *** hdl/drcs_osc.sv ***
`timescale 1ns/1ps
module drcs_osc #(
    parameter int unsigned HALF_CYC = drcs_pkg::OSC_HALF_CYC
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    output logic osc_o
);
    import drcs_pkg::*;
    logic [31:0] cnt;
    wire cnt_end = (cnt == HALF_CYC - 1);
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            cnt <= 32'h0000_0000;
            osc_o <= 1'b0;
        end else if (ce_i) begin
            cnt <= cnt_end ? 32'h0000_0000 : cnt + 32'h0000_0001;
            if (cnt_end) begin
                osc_o <= ~osc_o;
            end
        end
    end
endmodule : drcs_osc

// *** hdl/drcs_seq.sv ***
`timescale 1ns/1ps
// Notes on behaviour
// - Refresh happens on each falling edge of the refresh clock.
// - Refresh switches open on the rising edge, ending the refresh phase.
// - Internal mode uses an on-chip oscillator near 21 kHz.
// - In internal mode the oscillator may be driven out on the clock pin.
// - After reset: internal mode, clock pin not driven.
// - Select high takes the clock from the pin, low uses the oscillator.
// - All channels are refreshed on a continuous repeating cycle.
// - Capture-to-output latency depends on position in the cycle.
// - Large changes move at most one step size per refresh visit.
// - Each code is unsigned, 1024 equal steps between the references.
// - Eight independent 10-bit codes; each refresh uses the current one.
// - A 4-bit address selects channel; zero selects the first channel.
module drcs_seq #(
    parameter int unsigned HALF_CYC = drcs_pkg::OSC_HALF_CYC,
    parameter logic [drcs_pkg::CODE_W-1:0] SLEW_STEP =
        drcs_pkg::SLEW_STEP_RST
) (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic clock_source_select_i,
    input wire logic refresh_clock_pin_i,
    output logic refresh_clock_pin_o,
    output logic refresh_clock_pin_oe_o,
    input wire logic osc_out_en_i,
    input wire logic wr_i,
    input wire logic [drcs_pkg::ADDR_W-1:0] wr_addr_i,
    input wire logic [drcs_pkg::CODE_W-1:0] wr_code_i,
    output logic [drcs_pkg::CH_W-1:0] refresh_ch_o,
    output logic [drcs_pkg::CODE_W-1:0] refresh_code_o,
    output logic refresh_o,
    output logic switch_closed_o,
    output logic ext_mode_o
);
    import drcs_pkg::*;

    logic sel_s1, sel_s2, pin_s1, pin_s2, oen_s1, oen_s2;
    logic osc;
    logic clk_prev;
    logic [CH_W-1:0] ch;
    // Stored codes, and the levels that the refresh has reached so far
    logic [CODE_W-1:0] target [NUM_CH];
    logic [CODE_W-1:0] level [NUM_CH];
    drcs_phase_t phase;
    drcs_phase_t next_phase;

    // Distance between two codes, whichever of them is larger
    function automatic logic [CODE_W-1:0] code_dist(
        input logic [CODE_W-1:0] a,
        input logic [CODE_W-1:0] b
    );
        logic [STEP_W-1:0] diff;
        if (a > b) begin
            diff = {1'b0, a} - {1'b0, b};
        end else begin
            diff = {1'b0, b} - {1'b0, a};
        end
        code_dist = diff[CODE_W-1:0];
    endfunction : code_dist

    function automatic logic [CODE_W-1:0] slew_to(
        input logic [CODE_W-1:0] cur,
        input logic [CODE_W-1:0] tgt
    );
        logic near;
        near = (code_dist(cur, tgt) <= SLEW_STEP);
        if (near) begin
            slew_to = tgt;
        end else if (tgt > cur) begin
            slew_to = cur + SLEW_STEP;
        end else begin
            slew_to = cur - SLEW_STEP;
        end
    endfunction : slew_to

    // Oscillator runs in both modes, so the pin output stalls only while ce_i is low or rst_i is high
    drcs_osc #(
        .HALF_CYC(HALF_CYC)
    ) u_osc (
        .sys_clk_i(sys_clk_i),
        .rst_i(rst_i),
        .ce_i(ce_i),
        .osc_o(osc)
    );

    // Each pin passes two flops before any logic reads it
    // Mode select
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            sel_s1 <= 1'b0;
            sel_s2 <= 1'b0;
        end else if (ce_i) begin
            sel_s1 <= clock_source_select_i;
            sel_s2 <= sel_s1;
        end
    end

    // Refresh clock pin level
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            pin_s1 <= 1'b0;
            pin_s2 <= 1'b0;
        end else if (ce_i) begin
            pin_s1 <= refresh_clock_pin_i;
            pin_s2 <= pin_s1;
        end
    end

    // Enable for driving the oscillator out
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            oen_s1 <= 1'b0;
            oen_s2 <= 1'b0;
        end else if (ce_i) begin
            oen_s1 <= osc_out_en_i;
            oen_s2 <= oen_s1;
        end
    end

    wire ext_mode = sel_s2;
    wire ref_clk = ext_mode ? pin_s2 : osc;
    wire fall = clk_prev & ~ref_clk;
    wire rise = ~clk_prev & ref_clk;
    wire do_refresh = fall & (phase == DRCS_HOLD);
    wire do_advance = rise & (phase == DRCS_REFRESH);
    // Address bit 3 is ignored, so eight addresses alias onto 0..7
    wire [CH_W-1:0] wr_ch = wr_addr_i[CH_W-1:0];
    wire wr_take = ce_i & wr_i;
    wire [CH_W-1:0] next_ch = (ch == CH_LAST) ? CH_FIRST : ch + 3'h1;
    wire [CODE_W-1:0] next_level = slew_to(level[ch], target[ch]);

    // Pin driven only once software enables it and only in internal mode
    wire drive_pin = ~ext_mode & oen_s2;
    assign refresh_clock_pin_oe_o = drive_pin;
    assign refresh_clock_pin_o = osc;
    assign refresh_ch_o = ch;
    assign ext_mode_o = ext_mode;
    assign switch_closed_o = (phase == DRCS_REFRESH);

    // Writes land next cycle; address bit 3 plays no part
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            for (int i = 0; i < NUM_CH; i++) begin
                target[i] <= CODE_RST;
            end
        end else if (wr_take) begin
            target[wr_ch] <= wr_code_i;
        end
    end

    // Phase sequencing kept combinational so the clocked blocks stay short
    always_comb begin
        next_phase = phase;
        case (phase)
            DRCS_HOLD: begin
                if (fall) begin
                    next_phase = DRCS_REFRESH;
                end
            end
            DRCS_REFRESH: begin
                if (rise) begin
                    next_phase = DRCS_HOLD;
                end
            end
            default: begin
                next_phase = DRCS_HOLD;
            end
        endcase
    end

    // A change of source may show one false edge; it is acted on like any other edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            clk_prev <= 1'b0;
        end else if (ce_i) begin
            clk_prev <= ref_clk;
        end
    end

    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            refresh_o <= 1'b0;
        end else if (ce_i) begin
            refresh_o <= fall;
        end
    end

    // Switches stay closed from the falling edge to the rising edge
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            phase <= DRCS_HOLD;
        end else if (ce_i) begin
            phase <= next_phase;
        end
    end

    // Advance in the same cycle as the switches open, wrapping after the last
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            ch <= CH_FIRST;
        end else if (ce_i && do_advance) begin
            ch <= next_ch;
        end
    end

    // A code written just after its slot waits a whole round of eight
    // refresh periods; latency is traded for a single shared sequencer
    // Only the visited channel moves, so big changes take several rounds
    always_ff @(posedge sys_clk_i) begin
        if (rst_i) begin
            refresh_code_o <= CODE_RST;
            for (int i = 0; i < NUM_CH; i++) begin
                level[i] <= CODE_RST;
            end
        end else if (ce_i && do_refresh) begin
            level[ch] <= next_level;
            refresh_code_o <= next_level;
        end
    end
endmodule : drcs_seq

// *** shared/drcs_pkg.sv ***
package drcs_pkg;
    localparam int unsigned CLK_HZ = 200_000_000;
    localparam int unsigned OSC_HZ = 21_000;
    // Half period of the internal refresh oscillator, rounded down
    localparam int unsigned OSC_HALF_CYC = CLK_HZ / (2 * OSC_HZ);
    localparam int unsigned CODE_W = 10;
    localparam int unsigned CODE_STEPS = 1024;
    localparam int unsigned NUM_CH = 8;
    localparam int unsigned CH_W = 3;
    localparam int unsigned ADDR_W = 4;
    localparam int unsigned STEP_W = 11;
    // Largest code change per refresh visit (2V step size in codes)
    localparam logic [CODE_W-1:0] SLEW_STEP_RST = 10'h009d;
    localparam logic [CODE_W-1:0] CODE_RST = 10'h0000;
    localparam logic [CH_W-1:0] CH_FIRST = 3'h0;
    localparam logic [CH_W-1:0] CH_LAST = 3'h7;
    // Latency bounds in microseconds
    localparam int unsigned LAT_MIN_US = 48;
    localparam int unsigned LAT_MAX_US = 380;
    typedef enum logic [1:0] {
        DRCS_HOLD = 2'b01,
        DRCS_REFRESH = 2'b10
    } drcs_phase_t;
endpackage : drcs_pkg

// *** tb/drcs_line_clk.sv ***
`timescale 1ns/1ps
module drcs_line_clk (
    input wire logic en_i,
    output logic clk_o
);
    // Line-rate clock, rising edges kept clear of load steps
    initial begin
        clk_o = 1'b0;
        forever #31 clk_o = en_i ? !clk_o : clk_o;
    end
endmodule : drcs_line_clk

// *** tb/drcs_seq_properties.sv ***
`timescale 1ns/1ps
module drcs_seq_chk (
    input wire logic sys_clk_i,
    input wire logic rst_i,
    input wire logic ce_i,
    input wire logic refresh_clock_pin_i,
    input wire logic refresh_clock_pin_o,
    input wire logic refresh_clock_pin_oe_o,
    input wire logic [2:0] refresh_ch_o,
    input wire logic [9:0] refresh_code_o,
    input wire logic refresh_o,
    input wire logic switch_closed_o,
    input wire logic ext_mode_o
);
    default clocking @(posedge sys_clk_i);
    endclocking
    default disable iff (rst_i || !ce_i);
    a_refresh_pulse: assert property ($rose(switch_closed_o) |->
        refresh_o) else $error("no pulse");
    a_open_step: assert property ($fell(switch_closed_o) |->
        refresh_ch_o == $past(refresh_ch_o) + 3'h1) else $error("step");
    a_code_hold: assert property ($changed(refresh_code_o) |->
        $rose(switch_closed_o)) else $error("code");
    a_oe_internal: assert property (refresh_clock_pin_oe_o |->
        !ext_mode_o) else $error("oe");
    a_reset_hiz: assert property ($past(rst_i) |->
        !refresh_clock_pin_oe_o && !ext_mode_o) else $error("rst");
    a_ext_fall: assert property (ext_mode_o &&
        $fell(refresh_clock_pin_i) |-> ##3 switch_closed_o) else $error("xf");
    a_ext_rise: assert property (ext_mode_o &&
        $rose(refresh_clock_pin_i) |-> ##3 !switch_closed_o) else $error("xr");
    a_int_fall: assert property (!ext_mode_o &&
        $fell(refresh_clock_pin_o) |-> ##[0:2] switch_closed_o) else $error("i");
    c_ext_refresh: cover property (refresh_o && ext_mode_o);
    c_int_refresh: cover property (refresh_o && !ext_mode_o);
    c_pin_driven: cover property (refresh_clock_pin_oe_o);
endmodule : drcs_seq_chk

// *** tb/tb.sv ***
`timescale 1ns/1ps
module tb;
    import drcs_pkg::*;
    localparam int HC = 4;
    // One full round of refresh periods, plus synchroniser slack
    localparam int LAT_CYC = NUM_CH * 2 * HC + 4;
    logic clk = 1'b0, rst = 1'b1, sel = 1'b0, oen = 1'b0, wr = 1'b0;
    logic ce = 1'b1;
    logic [3:0] addr = 4'h0;
    logic [9:0] code = 10'h0000;
    logic ext, pin_o, oe, rf, sw, xm;
    logic [2:0] ch;
    logic [9:0] rc;
    wire pin = oe ? pin_o : ext;
    int err_count = 0;
    int n_tests = 0;
    initial begin
        forever #2.5 clk = !clk;
    end
    drcs_line_clk u_line (.en_i(sel), .clk_o(ext));
    drcs_seq #(.HALF_CYC(HC)) DUT (.sys_clk_i(clk), .rst_i(rst), .ce_i(ce),
        .clock_source_select_i(sel), .refresh_clock_pin_i(pin),
        .refresh_clock_pin_o(pin_o), .refresh_clock_pin_oe_o(oe),
        .osc_out_en_i(oen), .wr_i(wr), .wr_addr_i(addr), .wr_code_i(code),
        .refresh_ch_o(ch), .refresh_code_o(rc), .refresh_o(rf),
        .switch_closed_o(sw), .ext_mode_o(xm));
    task automatic results();
        $display("errors %0d checks %0d", err_count, n_tests);
        if (err_count == 0 && n_tests > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : results
    task automatic chk(string s, logic [9:0] e, logic [9:0] g);
        n_tests++;
        if (g !== e) begin
            err_count++;
            $display("[FAIL] %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task automatic tick(int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : tick
    // Bounded wait for the refresh pulse of one channel
    task automatic wait_ch(logic [2:0] c);
        int i;
        for (i = 0; i < 1000; i++) begin
            tick(1);
            if (rf === 1'b1 && ch === c) break;
        end
        if (i == 1000) begin
            err_count++;
            results();
        end
    endtask : wait_ch
    task automatic t_reset();
        chk("oe", 10'h0000, 10'(oe));
        chk("mode", 10'h0000, 10'(xm));
        chk("ch", 10'h0000, 10'(ch));
        chk("code", 10'h0000, rc);
    endtask : t_reset
    // Full-scale jump on channel A, address bit 3 set to show it is ignored
    task automatic t_slew();
        int e;
        int lat;
        realtime t0;
        addr = 4'h8;
        code = 10'h03ff;
        wr = 1'b1;
        tick(1);
        wr = 1'b0;
        t0 = $realtime;
        for (int k = 1; k <= 8; k++) begin
            wait_ch(3'h0);
            if (k == 1) begin
                lat = int'(($realtime - t0) / 5.0);
                n_tests++;
                if (lat > LAT_CYC) begin
                    err_count++;
                    $display("[FAIL] latency exp <= %0d got %0d",
                        LAT_CYC, lat);
                end
            end
            e = k * SLEW_STEP_RST;
            if (e > 1023) e = 1023;
            chk("slew", 10'(e), rc);
        end
        wait_ch(3'h1);
        chk("other", 10'h0000, rc);
    endtask : t_slew
    task automatic t_ext();
        sel = 1'b1;
        oen = 1'b1;
        tick(4);
        chk("mode", 10'h0001, 10'(xm));
        chk("oe", 10'h0000, 10'(oe));
        wait_ch(3'h3);
        sel = 1'b0;
        tick(4);
        chk("oe", 10'h0001, 10'(oe));
        wait_ch(3'h5);
    endtask : t_ext
    // Clock enable low freezes sequencer, pulse and code
    task automatic t_freeze();
        wait_ch(3'h2);
        ce = 1'b0;
        tick(20);
        chk("frz ch", 10'h0002, 10'(ch));
        chk("frz code", 10'h0000, rc);
        chk("frz pulse", 10'h0001, 10'(rf));
        ce = 1'b1;
        wait_ch(3'h3);
    endtask : t_freeze
    initial begin
        tick(6);
        rst = 1'b0;
        tick(1);
        t_reset();
        t_slew();
        t_ext();
        t_freeze();
        rst = 1'b1;
        tick(2);
        rst = 1'b0;
        tick(1);
        t_reset();
        results();
    end
endmodule : tb
bind drcs_seq drcs_seq_chk u_chk (.*);
